// File: logic/ccp_map.vh
`ifndef CCP_MAP_VH
`define CCP_MAP_VH
// Functional notes
// - Unpacker splits each beat into 36-bit pixels, two per clock nominally.
// - For 4:2:2 input, both pixels of a horizontal pair share U and V.
// - Repacker rebuilds 256-bit beats laid out by 4:2:2/4:4:4 and 8/16-bit type.
// - For 4:2:2 output each U and V is the horizontal pair average.
// - 12-bit components; 8-bit output keeps top eight, 16-bit appends four zeros.
// - Contrast stage sends 10-bit histogram value, aoi flag, skin flag to statistics.
// - Statistics track luma max, luma min and skin count, readable by software.
// - Each enhancement function has its own enable; disabled means pixels pass unchanged.
// - Four pixels per clock for 4:2:2 input, two for genuine 4:4:4.
// - Automatic chroma detection on 4:4:4 input compares upper 8 bits of U, V.
// - Block is 4:2:2 when UV of pixel 0 equals 1 and 2 equals 3.
// - Detected 4:2:2 runs four pixels per clock with horizontally averaged U, V.
// - Otherwise 4:4:4 input runs full 4:4:4 at two pixels per clock.
// - State flags force 4:2:2 on 4:4:4, 4:4:4 on 4:4:4, or 4:4:4 on 4:2:2.
// - In 4:4:4 mode repacker joins two pixel pairs from two clocks into one beat.

// Register byte offsets
`define CCP_REG_CTRL 8'h00
`define CCP_REG_STATUS 8'h04
`define CCP_REG_LUMA_MAX 8'h08
`define CCP_REG_LUMA_MIN 8'h0c
`define CCP_REG_SKIN 8'h10

// Control register fields
`define CCP_CTRL_EN_LSB 0
`define CCP_CTRL_CLR_BIT 8
`define CCP_CTRL_EN_RST 6'h00

// Status register fields
`define CCP_STAT_QUAD_BIT 0
`define CCP_STAT_DET_BIT 1

// Enable bit of the auto contrast stage inside the control field
`define CCP_EN_CONTRAST 2

// Enhancement state word flags
`define CCP_ST_IN422 0
`define CCP_ST_IN16 1
`define CCP_ST_OUT422 2
`define CCP_ST_OUT16 3
`define CCP_ST_F422_ON444 4
`define CCP_ST_F444_ON444 5
`define CCP_ST_F444_ON422 6

// Pipe tag fields
`define CCP_TAG_OUT16 0
`define CCP_TAG_OUT422 1
`define CCP_TAG_PHASE 2
`define CCP_TAG_QUAD 3

// Outgoing alpha for 4:4:4 beats, full scale
`define CCP_ALPHA_OUT 12'hfff

`endif

// File: logic/ccp_pack_unpack.v
// Local design decisions: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ccp_map.vh"

module ccp_pack_unpack #(
	parameter FN_N = 6,
	parameter HIST_W = 10,
	parameter CNT_W = 32
) (
	input wire ref_clk,
	input wire sys_rst,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg hreadyout,
	output reg [31:0] hrdata,
	output reg hresp,
	input wire in_valid,
	input wire [255:0] in_beat,
	input wire [255:0] in_state,
	output reg in_ready,
	output reg pipe_valid,
	output reg [95:0] pipe_word,
	output reg [3:0] pipe_tag,
	output reg [FN_N-1:0] fn_enable,
	input wire ret_valid,
	input wire [95:0] ret_word,
	input wire [3:0] ret_tag,
	input wire stat_valid,
	input wire [HIST_W-1:0] stat_hist,
	input wire stat_aoi,
	input wire stat_skin,
	output reg out_valid,
	output reg [255:0] out_beat
);

	// Component slot s of a beat: 16-bit lanes, or 8-bit lanes in the low half
	function [11:0] get_c;
		input [255:0] b;
		input [3:0] s;
		input w16;
		reg [15:0] f;
		begin
			f = b[{s, 4'h0} +: 16];
			if (w16) begin
				get_c = f[15:4];
			end else begin
				get_c = {b[{s, 3'h0} +: 8], 4'h0};
			end
		end
	endfunction

	function [255:0] put_c;
		input [255:0] b;
		input [3:0] s;
		input w16;
		input [11:0] c;
		begin
			put_c = b;
			if (w16) begin
				put_c[{s, 4'h0} +: 16] = {c, 4'h0};
			end else begin
				put_c[{s, 3'h0} +: 8] = c[11:4];
			end
		end
	endfunction

	function [11:0] avg_c;
		input [11:0] a;
		input [11:0] b;
		reg [12:0] t;
		begin
			t = {1'b0, a} + {1'b0, b};
			avg_c = t[12:1];
		end
	endfunction

	// Slot number of component c within pixel group g
	function [3:0] slot_ix;
		input [1:0] g;
		input [1:0] c;
		begin
			slot_ix = {g, c};
		end
	endfunction

	// Register bus
	// Transfer size is not decoded: whole words only
	reg wr_pend_reg;
	reg [7:0] wr_addr_reg;
	reg clr_pulse_reg;
	reg [31:0] rd_mux;
	wire ahb_go = hsel & htrans[1] & hready;
	wire [HIST_W-1:0] luma_max;
	wire [HIST_W-1:0] luma_min;
	wire [CNT_W-1:0] skin_cnt;

	// Unpacker
	reg [47:0] up_y;
	reg [47:0] up_u;
	reg [47:0] up_v;
	reg [3:0] sy;
	reg [3:0] su;
	reg [3:0] sv;
	reg [1:0] pi;
	integer i;
	reg detect_reg;
	reg quad_reg;
	reg half_pend_reg;
	reg [95:0] half_word_reg;
	reg [3:0] half_tag_reg;

	wire in422 = in_state[`CCP_ST_IN422];
	wire in16 = in_state[`CCP_ST_IN16];
	wire accept = in_valid & in_ready;

	always @* begin
		up_y = 48'h0000_0000_0000;
		up_u = 48'h0000_0000_0000;
		up_v = 48'h0000_0000_0000;
		sy = 4'h0;
		su = 4'h0;
		sv = 4'h0;
		pi = 2'b00;
		for (i = 0; i < 4; i = i + 1) begin
			pi = i[1:0];
			if (in422) begin
				sy = {1'b0, pi[1], pi[0], 1'b0};
				su = {1'b0, pi[1], 2'b01};
				sv = {1'b0, pi[1], 2'b11};
			end else begin
				sy = {pi, 2'b00};
				su = {pi, 2'b01};
				sv = {pi, 2'b10};
			end
			up_y[12*i +: 12] = get_c(in_beat, sy, in16);
			up_u[12*i +: 12] = get_c(in_beat, su, in16);
			up_v[12*i +: 12] = get_c(in_beat, sv, in16);
		end
	end

	// Only the upper eight bits take part, so noise in the low bits is tolerated
	wire detect = (up_u[11:4] == up_u[23:16]) && (up_u[35:28] == up_u[47:40]) &&
		(up_v[11:4] == up_v[23:16]) && (up_v[35:28] == up_v[47:40]);

	// Forcing 4:2:2 wins if software sets both 4:4:4-input flags
	wire quad_sel = in422 ? ~in_state[`CCP_ST_F444_ON422] :
		(in_state[`CCP_ST_F422_ON444] |
		(~in_state[`CCP_ST_F444_ON444] & detect));

	wire [95:0] word_quad = {avg_c(up_v[35:24], up_v[47:36]), avg_c(up_u[35:24], up_u[47:36]),
		avg_c(up_v[11:0], up_v[23:12]), avg_c(up_u[11:0], up_u[23:12]),
		up_y};
	wire [95:0] word_lo = {up_v[23:12], up_u[23:12], up_v[11:0], up_u[11:0],
		12'h000, up_y[23:12], 12'h000, up_y[11:0]};
	wire [95:0] word_hi = {up_v[47:36], up_u[47:36], up_v[35:24], up_u[35:24],
		12'h000, up_y[47:36], 12'h000, up_y[35:24]};
	// Format rides in the tag, so a new state word never reshapes older pixels
	wire [1:0] out_fmt = {in_state[`CCP_ST_OUT422], in_state[`CCP_ST_OUT16]};

	always @(posedge ref_clk) begin
		if (sys_rst) begin
			in_ready <= 1'b0;
			pipe_valid <= 1'b0;
			pipe_word <= 96'h0;
			pipe_tag <= 4'h0;
			half_pend_reg <= 1'b0;
			half_word_reg <= 96'h0;
			half_tag_reg <= 4'h0;
			detect_reg <= 1'b0;
			quad_reg <= 1'b0;
		end else begin
			// Second half of a two-pixel beat takes the next pipe slot
			in_ready <= ~(accept & ~quad_sel);
			if (accept) begin
				pipe_valid <= 1'b1;
				pipe_word <= quad_sel ? word_quad : word_lo;
				pipe_tag <= {quad_sel, 1'b0, out_fmt};
				half_pend_reg <= ~quad_sel;
				half_word_reg <= word_hi;
				half_tag_reg <= {1'b0, 1'b1, out_fmt};
				detect_reg <= ~in422 & detect;
				quad_reg <= quad_sel;
			end else if (half_pend_reg) begin
				pipe_valid <= 1'b1;
				pipe_word <= half_word_reg;
				pipe_tag <= half_tag_reg;
				half_pend_reg <= 1'b0;
			end else begin
				pipe_valid <= 1'b0;
			end
		end
	end

	// Return path: with every function off the stages are bypassed entirely
	wire en_any = |fn_enable;
	wire rs_valid = en_any ? ret_valid : pipe_valid;
	wire [95:0] rs_word = en_any ? ret_word : pipe_word;
	wire [3:0] rs_tag = en_any ? ret_tag : pipe_tag;
	wire rs_quad = rs_tag[`CCP_TAG_QUAD];
	wire rs_phase = rs_tag[`CCP_TAG_PHASE];
	wire rs_o422 = rs_tag[`CCP_TAG_OUT422];
	wire rs_o16 = rs_tag[`CCP_TAG_OUT16];

	// Repacker
	reg [71:0] acc_reg;
	reg [47:0] rp_y;
	reg [47:0] rp_u;
	reg [47:0] rp_v;
	reg [255:0] ob;
	reg [11:0] ua;
	reg [11:0] va;
	integer k;

	always @* begin
		if (rs_quad) begin
			rp_y = rs_word[47:0];
			rp_u = {rs_word[83:72], rs_word[83:72], rs_word[59:48], rs_word[59:48]};
			rp_v = {rs_word[95:84], rs_word[95:84], rs_word[71:60], rs_word[71:60]};
		end else begin
			rp_y = {rs_word[35:24], rs_word[11:0], acc_reg[47:36], acc_reg[11:0]};
			rp_u = {rs_word[83:72], rs_word[59:48], acc_reg[59:48], acc_reg[23:12]};
			rp_v = {rs_word[95:84], rs_word[71:60], acc_reg[71:60], acc_reg[35:24]};
		end
		ob = 256'h0;
		ua = 12'h000;
		va = 12'h000;
		for (k = 0; k < 4; k = k + 1) begin
			if (rs_o422) begin
				if (k < 2) begin
					ua = avg_c(rp_u[24*k +: 12], rp_u[24*k+12 +: 12]);
					va = avg_c(rp_v[24*k +: 12], rp_v[24*k+12 +: 12]);
					ob = put_c(ob, slot_ix(k[1:0], 2'h0), rs_o16, rp_y[24*k +: 12]);
					ob = put_c(ob, slot_ix(k[1:0], 2'h1), rs_o16, ua);
					ob = put_c(ob, slot_ix(k[1:0], 2'h2), rs_o16, rp_y[24*k+12 +: 12]);
					ob = put_c(ob, slot_ix(k[1:0], 2'h3), rs_o16, va);
				end
			end else begin
				ob = put_c(ob, slot_ix(k[1:0], 2'h0), rs_o16, rp_y[12*k +: 12]);
				ob = put_c(ob, slot_ix(k[1:0], 2'h1), rs_o16, rp_u[12*k +: 12]);
				ob = put_c(ob, slot_ix(k[1:0], 2'h2), rs_o16, rp_v[12*k +: 12]);
				ob = put_c(ob, slot_ix(k[1:0], 2'h3), rs_o16, `CCP_ALPHA_OUT);
			end
		end
	end

	// Phase-0 halves never leave alone; they wait in the accumulator
	wire emit = rs_valid & (rs_quad | rs_phase);

	always @(posedge ref_clk) begin
		if (sys_rst) begin
			acc_reg <= 72'h0;
			out_valid <= 1'b0;
			out_beat <= 256'h0;
		end else begin
			if (rs_valid && !rs_quad && !rs_phase) begin
				acc_reg <= {rs_word[95:84], rs_word[83:72], rs_word[35:24],
					rs_word[71:60], rs_word[59:48], rs_word[11:0]};
			end
			out_valid <= emit;
			if (emit) begin
				out_beat <= ob;
			end
		end
	end

	// Statistics only flow while the contrast stage is on
	ccp_stats #(
		.HIST_W(HIST_W),
		.CNT_W(CNT_W)
	) u_stats (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.clr(clr_pulse_reg),
		.ev_valid(stat_valid & fn_enable[`CCP_EN_CONTRAST]),
		.ev_hist(stat_hist),
		.ev_aoi(stat_aoi),
		.ev_skin(stat_skin),
		.luma_max_reg(luma_max),
		.luma_min_reg(luma_min),
		.skin_cnt_reg(skin_cnt)
	);

	// Unmapped offsets read as zero
	always @* begin
		case (haddr[7:0])
		`CCP_REG_CTRL: begin
			rd_mux = {{(32-FN_N){1'b0}}, fn_enable};
		end
		`CCP_REG_STATUS: begin
			rd_mux = {30'h0000_0000, detect_reg, quad_reg};
		end
		`CCP_REG_LUMA_MAX: begin
			rd_mux = {{(32-HIST_W){1'b0}}, luma_max};
		end
		`CCP_REG_LUMA_MIN: begin
			rd_mux = {{(32-HIST_W){1'b0}}, luma_min};
		end
		`CCP_REG_SKIN: begin
			rd_mux = skin_cnt;
		end
		default: begin
			rd_mux = 32'h0000_0000;
		end
		endcase
	end

	// Reads sample in the address phase so the slave never inserts wait states
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			hreadyout <= 1'b1;
			hrdata <= 32'h0000_0000;
			hresp <= 1'b0;
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			fn_enable <= `CCP_CTRL_EN_RST;
			clr_pulse_reg <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			// Write data follows its address by one cycle
			wr_pend_reg <= ahb_go & hwrite;
			if (ahb_go) begin
				wr_addr_reg <= haddr[7:0];
			end
			if (ahb_go && !hwrite) begin
				hrdata <= rd_mux;
			end
			clr_pulse_reg <= 1'b0;
			if (wr_pend_reg && wr_addr_reg == `CCP_REG_CTRL) begin
				fn_enable <= hwdata[`CCP_CTRL_EN_LSB +: FN_N];
				clr_pulse_reg <= hwdata[`CCP_CTRL_CLR_BIT];
			end
		end
	end

endmodule

`default_nettype wire

// File: logic/ccp_stats.v
`timescale 1ns/1ps
`default_nettype none
`include "ccp_map.vh"

module ccp_stats #(
	parameter HIST_W = 10,
	parameter CNT_W = 32
) (
	input wire ref_clk,
	input wire sys_rst,
	input wire clr,
	input wire ev_valid,
	input wire [HIST_W-1:0] ev_hist,
	input wire ev_aoi,
	input wire ev_skin,
	output reg [HIST_W-1:0] luma_max_reg,
	output reg [HIST_W-1:0] luma_min_reg,
	output reg [CNT_W-1:0] skin_cnt_reg
);

	reg [HIST_W-1:0] luma_max_next;
	reg [HIST_W-1:0] luma_min_next;
	reg [CNT_W-1:0] skin_cnt_next;

	// Clear first, then fold in a same-cycle event so it is never lost
	always @* begin
		luma_max_next = clr ? {HIST_W{1'b0}} : luma_max_reg;
		luma_min_next = clr ? {HIST_W{1'b1}} : luma_min_reg;
		skin_cnt_next = clr ? {CNT_W{1'b0}} : skin_cnt_reg;
		if (ev_valid && ev_aoi) begin
			if (ev_hist > luma_max_next) begin
				luma_max_next = ev_hist;
			end
			if (ev_hist < luma_min_next) begin
				luma_min_next = ev_hist;
			end
		end
		if (ev_valid && ev_skin) begin
			skin_cnt_next = skin_cnt_next + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	always @(posedge ref_clk) begin
		if (sys_rst) begin
			luma_max_reg <= {HIST_W{1'b0}};
			luma_min_reg <= {HIST_W{1'b1}};
			skin_cnt_reg <= {CNT_W{1'b0}};
		end else begin
			luma_max_reg <= luma_max_next;
			luma_min_reg <= luma_min_next;
			skin_cnt_reg <= skin_cnt_next;
		end
	end

endmodule

`default_nettype wire

// File: test/ccp_pack_unpack_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ccp_pack_unpack_asserts #(parameter FN_N = 6) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic hresp,
	input wire logic in_valid,
	input wire logic in_ready,
	input wire logic pipe_valid,
	input wire logic [3:0] pipe_tag,
	input wire logic [FN_N-1:0] fn_enable,
	input wire logic out_valid
);
	logic ctrl_wr;
	assign ctrl_wr = hsel && htrans[1] && hwrite && haddr[7:0] == 8'h00;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	bus_answer_a: assert property (hreadyout && !hresp)
		else $error("bad bus answer");
	beat_pipe_a: assert property (in_valid && in_ready |=> pipe_valid)
		else $error("beat not unpacked");
	dual_stall_a: assert property (
		pipe_valid && pipe_tag[3:2] == 2'h0 |-> !in_ready ##1 (pipe_valid && pipe_tag[2] && in_ready))
		else $error("bad two-pixel stall");
	quad_out_a: assert property (
		pipe_valid && pipe_tag[3] && ~|fn_enable |=> out_valid)
		else $error("quad beat lost");
	dual_join_a: assert property (
		pipe_valid && pipe_tag[3:2] == 2'h1 && ~|fn_enable |=> out_valid)
		else $error("pixel pair not joined");
	phase_wait_a: assert property (
		pipe_valid && pipe_tag[3:2] == 2'h0 && ~|fn_enable |=> !out_valid)
		else $error("half beat sent");
	enable_write_a: assert property (
		$changed(fn_enable) |-> $past(ctrl_wr, 2) && fn_enable == $past(hwdata[FN_N-1:0]))
		else $error("enables moved alone");
	unmapped_read_a: assert property (
		hsel && htrans[1] && !hwrite && haddr[7:0] == 8'h14 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
endmodule
bind ccp_pack_unpack ccp_pack_unpack_asserts #(.FN_N(FN_N)) chk_u (.*);
`default_nettype wire

// File: test/ccp_pack_unpack_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ccp_pack_unpack_tb_top;
	localparam logic [127:0] px_a = 128'h8877_6655_4433_2211;
	localparam logic [127:0] px_b = 128'h0090_5060_0090_5030_0080_4020_0080_4010;
	localparam logic [127:0] px_n = 128'h0090_5060_0090_5030_0080_4120_0080_4010;
	localparam logic [127:0] px_c = 128'h0066_4404_0066_4403_0090_3002_0070_1001;
	localparam logic [255:0] px_w = {128'h0000_9000_5000_6000_0000_9000_5000_3000,
		128'h0000_8000_40f0_2000_0000_8000_4010_1000};
	localparam logic [127:0] px_e = 128'h9000_6000_5000_3000_8000_2000_4080_1000;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic hsel = 1'b0, hwrite = 1'b0, in_valid = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
	logic [255:0] in_beat = 256'h0, in_state = 256'h0;
	wire logic hreadyout, hresp, in_ready, pipe_valid, ret_valid, out_valid;
	wire logic stat_valid, stat_aoi, stat_skin;
	wire logic [3:0] pipe_tag, ret_tag;
	wire logic [5:0] fn_enable;
	wire logic [9:0] stat_hist;
	wire logic [31:0] hrdata;
	wire logic [95:0] pipe_word, ret_word;
	wire logic [255:0] out_beat;
	logic [255:0] outq[$];
	int err_total = 0;
	int samples_checked = 0;

	// Lone slave, so its ready is the bus ready
	ccp_pack_unpack dut_u (.*, .hsize(3'h2), .hready(hreadyout));
	ccp_stage_model stage_u (.*);

	always #4 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		if (out_valid === 1'b1)
			outq.push_back(out_beat);
	end

	task automatic test_done;
		$display("compares %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk_beat(input logic [255:0] g, input logic [255:0] e);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
		chk_beat({224'h0, g}, {224'h0, e});
	endtask

	// Master never assumes the slave answers at once
	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			err_total++;
			test_done();
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		rd = hrdata;
	endtask

	task automatic beat_w(input logic [7:0] st, input logic [255:0] b, input logic [255:0] e);
		int n;
		n = 0;
		in_valid <= 1'b1;
		in_beat <= b;
		in_state <= {248'h0, st};
		do begin
			@(posedge ref_clk);
			n++;
		end while (in_ready !== 1'b1 && n < 20);
		in_valid <= 1'b0;
		if (in_ready !== 1'b1) begin
			err_total++;
			test_done();
		end
		n = 0;
		while (outq.size() == 0 && n < 20) begin
			@(posedge ref_clk);
			n++;
		end
		if (outq.size() == 0) begin
			err_total++;
			test_done();
		end
		chk_beat(outq.pop_front(), e);
	endtask

	task automatic beat(input logic [7:0] st, input logic [127:0] b, input logic [127:0] e);
		beat_w(st, {128'h0, b}, {128'h0, e});
	endtask

	task automatic t_regs;
		logic [7:0] a[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
		logic [31:0] e[6] = '{32'h0, 32'h0, 32'h0, 32'h3ff, 32'h0, 32'h0};
		foreach (a[i]) begin
			bus(1'b0, a[i], 32'h0);
			chk_reg(rd, e[i]);
		end
		bus(1'b1, 8'h00, 32'hffff_ff3f);
		bus(1'b1, 8'h14, 32'hffff_ffff);
		bus(1'b0, 8'h00, 32'h0);
		chk_reg(rd, 32'h3f);
		bus(1'b0, 8'h14, 32'h0);
		chk_reg(rd, 32'h0);
		bus(1'b1, 8'h00, 32'h0);
	endtask

	task automatic t_in422;
		beat(8'h05, px_a, px_a);
		beat(8'h0d, px_a, 128'h8800_7700_6600_5500_4400_3300_2200_1100);
	endtask

	task automatic t_detect;
		beat(8'h04, px_b, 128'h9060_5030_8020_4010);
		bus(1'b0, 8'h04, 32'h0);
		chk_reg(rd, 32'h3);
		beat(8'h20, px_b, 128'hff90_5060_ff90_5030_ff80_4020_ff80_4010);
		beat(8'h00, px_n, 128'hff90_5060_ff90_5030_ff80_4120_ff80_4010);
		bus(1'b0, 8'h04, 32'h0);
		chk_reg(rd, 32'h0);
	endtask

	task automatic t_force;
		beat(8'h34, px_c, 128'h6604_4403_8002_2001);
		beat(8'h41, px_a, 128'hff88_6677_ff88_6655_ff44_2233_ff44_2211);
	endtask

	task automatic t_stats;
		bus(1'b1, 8'h00, 32'h4);
		beat(8'h05, px_a, px_a);
		beat(8'h05, 128'h8877_6655_4433_2299, 128'h8877_6655_4433_2299);
		bus(1'b0, 8'h08, 32'h0);
		chk_reg(rd, 32'h264);
		bus(1'b0, 8'h0c, 32'h0);
		chk_reg(rd, 32'h44);
		bus(1'b0, 8'h10, 32'h0);
		chk_reg(rd, 32'h2);
		bus(1'b1, 8'h00, 32'h100);
		// Clear passes two register stages before the count drops
		@(posedge ref_clk);
		bus(1'b0, 8'h10, 32'h0);
		chk_reg(rd, 32'h0);
	endtask

	task automatic t_wide;
		beat_w(8'h0e, px_w, {128'h0, px_e});
		bus(1'b0, 8'h04, 32'h0);
		chk_reg(rd, 32'h3);
		beat(8'h2c, px_n, px_e);
	endtask

	initial begin
		repeat (10) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		t_regs();
		t_in422();
		t_detect();
		t_force();
		t_wide();
		t_stats();
		test_done();
	end
endmodule
`default_nettype wire

// File: test/ccp_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
module ccp_stage_model (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic pipe_valid,
	input wire logic [95:0] pipe_word,
	input wire logic [3:0] pipe_tag,
	output logic ret_valid,
	output logic [95:0] ret_word,
	output logic [3:0] ret_tag,
	output logic stat_valid,
	output logic [9:0] stat_hist,
	output logic stat_aoi,
	output logic stat_skin
);
	// Idle cycles scramble the words so a stale one cannot pass
	always @(posedge ref_clk) begin
		ret_valid <= pipe_valid && !sys_rst;
		ret_word <= (pipe_valid || sys_rst) ? pipe_word : ~ret_word;
		ret_tag <= (pipe_valid || sys_rst) ? pipe_tag : ~ret_tag;
		stat_valid <= pipe_valid && !sys_rst;
		stat_hist <= pipe_word[11:2];
		stat_aoi <= 1'b1;
		stat_skin <= 1'b1;
	end
endmodule
`default_nettype wire
